// file: core/node_status_pkg.sv
package node_status_pkg;
	localparam int NODE_COUNT = 4;
	localparam int NODE_W = 2;
	localparam int QUEUE_DEPTH = 10;
	localparam int QCOUNT_W = 4;

	localparam logic [11:0] OFS_CTRL = 12'h000;
	localparam logic [11:0] OFS_NODE_BASE = 12'h100;
	localparam logic [11:0] OFS_NODE_STRIDE = 12'h010;
	localparam logic [3:0] SUB_STATUS = 4'h0;
	localparam logic [3:0] SUB_ACTUAL = 4'h4;
	localparam logic [3:0] SUB_HOSTCTL = 4'h8;
	localparam logic [3:0] SUB_QUEUE = 4'hc;

	localparam int BIT_EXCHANGE = 0;
	localparam int BIT_FAULT = 1;
	localparam int BIT_ALARM_WAIT = 2;
	localparam int BIT_DIAG_WAIT = 3;
	localparam int BIT_ADDR_CONF = 4;
	localparam int BIT_MAP_CONF = 5;
	localparam int BIT_CLEAR_N = 6;
	localparam int BIT_UNACKED = 7;
	localparam int BIT_IDENT = 8;
	localparam int POS_ACT_STATION = 0;
	localparam int POS_ACT_CHECKSUM = 8;
	localparam int POS_HOST_STATION = 0;
	localparam int POS_ALARM_RAISE = 8;
	localparam int POS_HOST_CHECKSUM = 16;
	localparam int POS_SLAVE_MODE = 0;

	localparam logic [7:0] RST_STATION = 8'h00;
	localparam logic [15:0] RST_CHECKSUM = 16'h0000;

	typedef struct packed {
		logic exchange;
		logic rx_valid;
		logic size_error;
		logic link_fault;
		logic identity_conflict;
		logic alarm_set;
		logic alarm_unloaded;
		logic diag_set;
		logic diag_unloaded;
		logic clear_mode;
		logic alarm_acked;
		logic [7:0] station_no;
		logic [15:0] map_checksum;
	} node_event_t;

	typedef struct packed {
		logic valid;
		logic class2;
		logic from_exchange_master;
		logic [1:0] node;
	} acyc_req_t;
endpackage

// file: core/fieldbus_node_status_control.sv
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/100ps
module fieldbus_node_status_control (
	input wire logic SYS_CLK_IN,
	input wire logic SYS_RST_IN,
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [11:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	output logic [31:0] PRDATA_OUT,
	output logic PREADY_OUT,
	output logic PSLVERR_OUT,
	input wire node_status_pkg::node_event_t NODE_EVT_IN [node_status_pkg::NODE_COUNT],
	input wire node_status_pkg::acyc_req_t ACYC_REQ_IN,
	output logic ACYC_REQ_READY_OUT,
	output logic ACYC_REQ_REJECT_OUT,
	input wire logic ACYC_DONE_IN,
	output logic [node_status_pkg::NODE_COUNT-1:0] ALARM_SEND_OUT,
	output logic SLAVE_MODE_OUT
);
	localparam int N = node_status_pkg::NODE_COUNT;

	// control word
	logic slave_mode;
	logic next_slave_mode;

	// per-node status flags
	logic [N-1:0] fault;
	logic [N-1:0] next_fault;
	logic [N-1:0] alarm_wait;
	logic [N-1:0] next_alarm_wait;
	logic [N-1:0] diag_wait;
	logic [N-1:0] next_diag_wait;
	logic [N-1:0] exch;
	logic [N-1:0] next_exch;
	logic [N-1:0] clear_n;
	logic [N-1:0] next_clear_n;
	logic [N-1:0] ident;
	logic [N-1:0] next_ident;
	logic [7:0] act_station [N];
	logic [7:0] next_act_station [N];
	logic [15:0] act_checksum [N];
	logic [15:0] next_act_checksum [N];

	// per-node alarm handshake
	logic [N-1:0] unacked;
	logic [N-1:0] next_unacked;
	logic [N-1:0] raise_prev;
	logic [N-1:0] next_raise_prev;
	logic [N-1:0] alarm_send;
	logic [N-1:0] next_alarm_send;

	// per-node host control
	logic [7:0] host_station [N];
	logic [7:0] next_host_station [N];
	logic [15:0] host_checksum [N];
	logic [15:0] next_host_checksum [N];
	logic [N-1:0] host_raise;
	logic [N-1:0] next_host_raise;

	// acyclic queue
	logic [node_status_pkg::QCOUNT_W-1:0] qcount;
	logic [node_status_pkg::QCOUNT_W-1:0] next_qcount;
	logic req_ready;
	logic next_req_ready;
	logic req_reject;
	logic next_req_reject;

	// register bus answer
	logic [31:0] prdata;
	logic [31:0] next_prdata;
	logic pready;
	logic next_pready;
	logic pslverr;
	logic next_pslverr;

	logic apb_wr;
	logic apb_rd;
	logic node_hit;
	logic [node_status_pkg::NODE_W-1:0] sel_node;
	logic [3:0] sub;
	logic accept;
	logic complete;
	logic [11:0] node_ofs;

	// node window: base + node * stride + sub-register
	assign node_ofs = PADDR_IN - node_status_pkg::OFS_NODE_BASE;
	assign sel_node = node_ofs[4 +: node_status_pkg::NODE_W];
	assign sub = node_ofs[3:0];
	assign node_hit = (PADDR_IN >= node_status_pkg::OFS_NODE_BASE)
		&& (node_ofs[11:4] < 8'(N)) && (PADDR_IN[1:0] == 2'h0);
	assign apb_wr = PSEL_IN && PENABLE_IN && PWRITE_IN && !pready;
	assign apb_rd = PSEL_IN && PENABLE_IN && !PWRITE_IN && !pready;

	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_node
			node_status_pkg::node_event_t ev;
			logic host_wr;
			assign ev = NODE_EVT_IN[g];
			assign host_wr = apb_wr && node_hit && int'(sel_node) == g
				&& sub == node_status_pkg::SUB_HOSTCTL;

			// status group: exch, ident and the actual values follow the far side one edge late; fault and the wait flags latch
			always_comb begin
				next_exch[g] = ev.exchange;
				next_ident[g] = ev.identity_conflict;
				// a new fault beats a valid response arriving together
				if (ev.size_error || ev.link_fault || ev.identity_conflict) begin
					next_fault[g] = 1'b1;
				end else if (ev.rx_valid) begin
					next_fault[g] = 1'b0;
				end else begin
					next_fault[g] = fault[g];
				end
				// a set beats an unload in the same cycle, so no alarm is lost
				next_alarm_wait[g] = ev.alarm_set | (alarm_wait[g] & ~ev.alarm_unloaded);
				next_diag_wait[g] = ev.diag_set | (diag_wait[g] & ~ev.diag_unloaded);
				next_clear_n[g] = slave_mode ? ~ev.clear_mode : 1'b1;
				next_act_station[g] = ev.station_no;
				next_act_checksum[g] = ev.map_checksum;
			end

			always_ff @(posedge SYS_CLK_IN) begin
				if (SYS_RST_IN) begin
					exch[g] <= 1'b0;
					ident[g] <= 1'b0;
					fault[g] <= 1'b0;
					alarm_wait[g] <= 1'b0;
					diag_wait[g] <= 1'b0;
					clear_n[g] <= 1'b1;
					act_station[g] <= node_status_pkg::RST_STATION;
					act_checksum[g] <= node_status_pkg::RST_CHECKSUM;
				end else begin
					exch[g] <= next_exch[g];
					ident[g] <= next_ident[g];
					fault[g] <= next_fault[g];
					alarm_wait[g] <= next_alarm_wait[g];
					diag_wait[g] <= next_diag_wait[g];
					clear_n[g] <= next_clear_n[g];
					act_station[g] <= next_act_station[g];
					act_checksum[g] <= next_act_checksum[g];
				end
			end

			// alarm group: the send pulse is worked out first, unacked depends on it
			always_comb begin
				next_raise_prev[g] = host_raise[g];
				next_alarm_send[g] = slave_mode && host_raise[g] && !raise_prev[g];
				// unacked is forced to 1 outside slave mode; a fresh alarm re-arms it, an ack clears it
				if (!slave_mode || next_alarm_send[g]) begin
					next_unacked[g] = 1'b1;
				end else if (ev.alarm_acked) begin
					next_unacked[g] = 1'b0;
				end else begin
					next_unacked[g] = unacked[g];
				end
			end

			always_ff @(posedge SYS_CLK_IN) begin
				if (SYS_RST_IN) begin
					unacked[g] <= 1'b1;
					raise_prev[g] <= 1'b0;
					alarm_send[g] <= 1'b0;
				end else begin
					unacked[g] <= next_unacked[g];
					raise_prev[g] <= next_raise_prev[g];
					alarm_send[g] <= next_alarm_send[g];
				end
			end

			// host group: written only over the register bus
			always_comb begin
				next_host_station[g] = host_station[g];
				next_host_checksum[g] = host_checksum[g];
				next_host_raise[g] = host_raise[g];
				if (host_wr) begin
					next_host_station[g] = PWDATA_IN[node_status_pkg::POS_HOST_STATION +: 8];
					next_host_checksum[g] = PWDATA_IN[node_status_pkg::POS_HOST_CHECKSUM +: 16];
					next_host_raise[g] = PWDATA_IN[node_status_pkg::POS_ALARM_RAISE];
				end
			end

			always_ff @(posedge SYS_CLK_IN) begin
				if (SYS_RST_IN) begin
					host_station[g] <= node_status_pkg::RST_STATION;
					host_checksum[g] <= node_status_pkg::RST_CHECKSUM;
					host_raise[g] <= 1'b0;
				end else begin
					host_station[g] <= next_host_station[g];
					host_checksum[g] <= next_host_checksum[g];
					host_raise[g] <= next_host_raise[g];
				end
			end
		end
	endgenerate

	// acyclic request gate and outstanding counter
	always_comb begin
		accept = 1'b0;
		if (ACYC_REQ_IN.valid && qcount < 4'(node_status_pkg::QUEUE_DEPTH)) begin
			if (ACYC_REQ_IN.class2) begin
				accept = 1'b1;
			end else begin
				// live level and registered copy must both show exchange,
				// so a node that drops out is refused at once
				accept = exch[ACYC_REQ_IN.node]
					&& NODE_EVT_IN[ACYC_REQ_IN.node].exchange
					&& ACYC_REQ_IN.from_exchange_master;
			end
		end
		// a done with nothing outstanding is dropped so the count cannot wrap
		complete = ACYC_DONE_IN && qcount != 4'h0;
		next_qcount = qcount;
		if (accept && !complete) begin
			next_qcount = qcount + 4'h1;
		end else if (complete && !accept) begin
			next_qcount = qcount - 4'h1;
		end
		next_req_ready = accept;
		next_req_reject = ACYC_REQ_IN.valid && !accept;
	end

	always_ff @(posedge SYS_CLK_IN) begin
		if (SYS_RST_IN) begin
			qcount <= 4'h0;
			req_ready <= 1'b0;
			req_reject <= 1'b0;
		end else begin
			qcount <= next_qcount;
			req_ready <= next_req_ready;
			req_reject <= next_req_reject;
		end
	end

	// control word: mode changes only on a write that the bus takes
	always_comb begin
		next_slave_mode = slave_mode;
		if (apb_wr && PADDR_IN == node_status_pkg::OFS_CTRL) begin
			next_slave_mode = PWDATA_IN[node_status_pkg::POS_SLAVE_MODE];
		end
	end

	always_ff @(posedge SYS_CLK_IN) begin
		if (SYS_RST_IN) begin
			slave_mode <= 1'b0;
		end else begin
			slave_mode <= next_slave_mode;
		end
	end

	// apb read mux; one wait state, so pready is registered
	always_comb begin
		next_pready = PSEL_IN && PENABLE_IN && !pready;
		next_pslverr = 1'b0;
		next_prdata = 32'h0000_0000;
		if (apb_rd || apb_wr) begin
			if (PADDR_IN == node_status_pkg::OFS_CTRL) begin
				next_prdata = {28'h0, qcount[2:0], slave_mode};
			end else if (node_hit) begin
				case (sub)
					node_status_pkg::SUB_STATUS: begin
						next_prdata[node_status_pkg::BIT_EXCHANGE] = exch[sel_node];
						next_prdata[node_status_pkg::BIT_FAULT] = fault[sel_node];
						next_prdata[node_status_pkg::BIT_ALARM_WAIT] = alarm_wait[sel_node];
						next_prdata[node_status_pkg::BIT_DIAG_WAIT] = diag_wait[sel_node];
						next_prdata[node_status_pkg::BIT_ADDR_CONF] =
							act_station[sel_node] != host_station[sel_node];
						next_prdata[node_status_pkg::BIT_MAP_CONF] =
							act_checksum[sel_node] != host_checksum[sel_node];
						next_prdata[node_status_pkg::BIT_CLEAR_N] = clear_n[sel_node];
						next_prdata[node_status_pkg::BIT_UNACKED] = unacked[sel_node];
						next_prdata[node_status_pkg::BIT_IDENT] = ident[sel_node];
					end
					node_status_pkg::SUB_ACTUAL: begin
						next_prdata = {act_checksum[sel_node], 8'h00, act_station[sel_node]};
					end
					node_status_pkg::SUB_HOSTCTL: begin
						next_prdata = {host_checksum[sel_node], 7'h00, host_raise[sel_node],
							host_station[sel_node]};
					end
					node_status_pkg::SUB_QUEUE: begin
						next_prdata = {28'h0, qcount};
					end
					default: begin
						next_pslverr = 1'b1;
					end
				endcase
			end else begin
				next_pslverr = 1'b1;
			end
			if (apb_wr) begin
				next_prdata = 32'h0000_0000;
			end
		end
	end

	// bus answer registers; read data stands only in the ready cycle
	always_ff @(posedge SYS_CLK_IN) begin
		if (SYS_RST_IN) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
		end
	end

	assign PRDATA_OUT = prdata;
	assign PREADY_OUT = pready;
	assign PSLVERR_OUT = pslverr;
	assign ACYC_REQ_READY_OUT = req_ready;
	assign ACYC_REQ_REJECT_OUT = req_reject;
	assign ALARM_SEND_OUT = alarm_send;
	assign SLAVE_MODE_OUT = slave_mode;
endmodule

// file: verif/node_partner.sv
`timescale 1ns/100ps
module node_partner (
	input wire logic clk_in,
	output node_status_pkg::node_event_t evt_out [node_status_pkg::NODE_COUNT],
	output node_status_pkg::acyc_req_t req_out,
	output logic done_out
);
	initial begin
		evt_out = '{default: '0};
		req_out = '0;
		done_out = 1'b0;
	end
	// level fields stay until the next put, as a slave's line state would
	task put(input int n, input node_status_pkg::node_event_t v);
		@(posedge clk_in);
		evt_out[n] <= v;
	endtask
	// base is read after the edge so a put just before has already landed
	task pulse(input int n, input node_status_pkg::node_event_t v);
		node_status_pkg::node_event_t base;
		@(posedge clk_in);
		base = evt_out[n];
		evt_out[n] <= base | v;
		@(posedge clk_in);
		evt_out[n] <= base;
	endtask
	task acyc(input logic c2, input logic fem, input logic [1:0] node);
		@(posedge clk_in);
		req_out <= '{1'b1, c2, fem, node}; // targets are taken as dpv1 enabled
		@(posedge clk_in);
		req_out.valid <= 1'b0;
	endtask
	task done();
		@(posedge clk_in);
		done_out <= 1'b1;
		@(posedge clk_in);
		done_out <= 1'b0;
	endtask
endmodule

// file: verif/fieldbus_node_status_control_props.sv
`timescale 1ns/100ps
module node_status_props (
	input wire logic SYS_CLK_IN,
	input wire logic SYS_RST_IN,
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PREADY_OUT,
	input wire logic PSLVERR_OUT,
	input wire node_status_pkg::node_event_t NODE_EVT_IN [node_status_pkg::NODE_COUNT],
	input wire node_status_pkg::acyc_req_t ACYC_REQ_IN,
	input wire logic ACYC_REQ_READY_OUT,
	input wire logic ACYC_REQ_REJECT_OUT,
	input wire logic [node_status_pkg::NODE_COUNT-1:0] ALARM_SEND_OUT,
	input wire logic SLAVE_MODE_OUT
);
	default clocking cb @(posedge SYS_CLK_IN);
	endclocking
	default disable iff (SYS_RST_IN);
	AST_APB_WAIT: assert property (PSEL_IN && PENABLE_IN && !PREADY_OUT |=> PREADY_OUT)
		else $error("apb access not answered after one wait state");
	AST_APB_PULSE: assert property (PREADY_OUT |=> !PREADY_OUT)
		else $error("pready held longer than one cycle");
	AST_ERR_READY: assert property (PSLVERR_OUT |-> PREADY_OUT)
		else $error("pslverr without pready");
	AST_ACYC_ANSWER: assert property (ACYC_REQ_IN.valid |=> ACYC_REQ_READY_OUT != ACYC_REQ_REJECT_OUT)
		else $error("acyclic request not answered exactly once");
	AST_ACYC_QUIET: assert property (!ACYC_REQ_IN.valid |=> !ACYC_REQ_READY_OUT && !ACYC_REQ_REJECT_OUT)
		else $error("acyclic answer without request");
	AST_C1_GATE: assert property (ACYC_REQ_IN.valid && !ACYC_REQ_IN.class2 &&
		!(NODE_EVT_IN[ACYC_REQ_IN.node].exchange && ACYC_REQ_IN.from_exchange_master)
		|=> ACYC_REQ_REJECT_OUT) else $error("class 1 request accepted outside exchange");
	AST_ALARM_SLAVE: assert property (ALARM_SEND_OUT != '0 |-> SLAVE_MODE_OUT)
		else $error("alarm sent outside slave mode");
	AST_ALARM_ONCE: assert property ($rose(ALARM_SEND_OUT[0]) |=> $fell(ALARM_SEND_OUT[0]))
		else $error("alarm send longer than one cycle");
endmodule
bind fieldbus_node_status_control node_status_props chk_u (.SYS_CLK_IN(SYS_CLK_IN),
	.SYS_RST_IN(SYS_RST_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PREADY_OUT(PREADY_OUT),
	.PSLVERR_OUT(PSLVERR_OUT), .NODE_EVT_IN(NODE_EVT_IN), .ACYC_REQ_IN(ACYC_REQ_IN),
	.ACYC_REQ_READY_OUT(ACYC_REQ_READY_OUT), .ACYC_REQ_REJECT_OUT(ACYC_REQ_REJECT_OUT),
	.ALARM_SEND_OUT(ALARM_SEND_OUT), .SLAVE_MODE_OUT(SLAVE_MODE_OUT));

// file: verif/tb.sv
`timescale 1ns/100ps
module tb;
	logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rdata;
	logic pready, pslverr, serr, rdy, rej, done, smode;
	logic [3:0] asend;
	node_status_pkg::node_event_t evt [node_status_pkg::NODE_COUNT];
	node_status_pkg::acyc_req_t req;
	int err_count, compares, alarms;
	localparam int EX = 34, RX = 33, SZ = 32, LF = 31, ID = 30, AS = 29, AU = 28;
	localparam int DS = 27, DU = 26, CM = 25, AK = 24;
	always #50 clk = ~clk;
	always @(posedge clk) if (asend[0]) alarms++;
	fieldbus_node_status_control dut_u (.SYS_CLK_IN(clk), .SYS_RST_IN(rst), .PSEL_IN(psel),
		.PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
		.PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .NODE_EVT_IN(evt),
		.ACYC_REQ_IN(req), .ACYC_REQ_READY_OUT(rdy), .ACYC_REQ_REJECT_OUT(rej),
		.ACYC_DONE_IN(done), .ALARM_SEND_OUT(asend), .SLAVE_MODE_OUT(smode));
	node_partner part_u (.clk_in(clk), .evt_out(evt), .req_out(req), .done_out(done));
	function automatic node_status_pkg::node_event_t b(input int i);
		b = '0;
		b[i] = 1'b1;
	endfunction
	function automatic logic [11:0] ad(input int n, input logic [3:0] s);
		ad = node_status_pkg::OFS_NODE_BASE + 12'(n) * node_status_pkg::OFS_NODE_STRIDE + {8'h0, s};
	endfunction
	task end_sim();
		$display("mismatches %0d comparisons %0d", err_count, compares);
		if (err_count == 0 && compares > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] x);
		compares++;
		if (g !== x) begin
			err_count++;
			$display("wrong value at %0t: got %h want %h", $time, g, x);
		end
	endtask
	// request stands until pready is sampled high at a rising edge; data is taken there
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rdata = prdata;
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rd(input logic [11:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(rdata, x);
	endtask
	task areq(input logic c2, input logic fem, input logic [1:0] n, input logic [31:0] x);
		part_u.acyc(c2, fem, n);
		#1 chk({30'h0, rdy, rej}, x);
	endtask
	initial begin
		repeat (5000) @(posedge clk);
		err_count++;
		end_sim();
	end
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		rd(ad(0, node_status_pkg::SUB_STATUS), 32'h0c0);
		part_u.pulse(0, b(SZ));
		rd(ad(0, node_status_pkg::SUB_STATUS), 32'h0c2);
		part_u.pulse(0, b(RX));
		rd(ad(0, node_status_pkg::SUB_STATUS), 32'h0c0);
		part_u.pulse(0, b(LF));
		rd(ad(0, node_status_pkg::SUB_STATUS), 32'h0c2);
		part_u.put(0, b(ID));
		rd(ad(0, node_status_pkg::SUB_STATUS), 32'h1c2);
		part_u.put(0, '0);
		part_u.pulse(0, b(AS) | b(DS));
		rd(ad(0, node_status_pkg::SUB_STATUS), 32'h0ce);
		part_u.pulse(0, b(AU) | b(DU) | b(RX));
		rd(ad(0, node_status_pkg::SUB_STATUS), 32'h0c0);
		part_u.put(0, b(EX));
		rd(ad(0, node_status_pkg::SUB_STATUS), 32'h0c1);
		part_u.put(1, 35'h12beef);
		rd(ad(1, node_status_pkg::SUB_ACTUAL), 32'hbeef0012);
		rd(ad(1, node_status_pkg::SUB_STATUS), 32'h0f0);
		apb(1'b1, ad(1, node_status_pkg::SUB_HOSTCTL), 32'hbeef0012);
		apb(1'b1, ad(1, node_status_pkg::SUB_ACTUAL), 32'h0);
		rd(ad(1, node_status_pkg::SUB_ACTUAL), 32'hbeef0012);
		rd(ad(1, node_status_pkg::SUB_HOSTCTL), 32'hbeef0012);
		rd(ad(1, node_status_pkg::SUB_STATUS), 32'h0c0);
		apb(1'b0, 12'h0f0, 32'h0);
		chk({31'h0, serr}, 32'h1);
		apb(1'b1, node_status_pkg::OFS_CTRL, 32'h1);
		chk({31'h0, smode}, 32'h1);
		part_u.put(0, b(EX) | b(CM));
		rd(ad(0, node_status_pkg::SUB_STATUS), 32'h081);
		// the second identical write must not send again: only the edge counts
		repeat (2) begin
			apb(1'b1, ad(0, node_status_pkg::SUB_HOSTCTL), 32'h100);
			repeat (4) @(posedge clk);
			chk(alarms, 1);
		end
		part_u.pulse(0, b(AK));
		rd(ad(0, node_status_pkg::SUB_STATUS), 32'h001);
		areq(1'b0, 1'b1, 2'd0, 32'h2);
		areq(1'b0, 1'b0, 2'd0, 32'h1);
		areq(1'b0, 1'b1, 2'd2, 32'h1);
		repeat (9) areq(1'b1, 1'b0, 2'd2, 32'h2);
		areq(1'b1, 1'b0, 2'd2, 32'h1);
		rd(ad(0, node_status_pkg::SUB_QUEUE), 32'h00a);
		part_u.done();
		areq(1'b1, 1'b0, 2'd1, 32'h2);
		end_sim();
	end
endmodule
